// ---- lpwc_cpu_model.sv ----
// Purpose: Behavioural processor core that issues wait instructions to the mode controller.
// Assumes: The bench asks for an instruction with cmd_i; 1 is wait-for-event, 2 is wait-for-interrupt.
// Notes:   A core without a clock executes nothing, so requests are dropped while the core clock is gated.
`timescale 1ns/1ps
`default_nettype none

module lpwc_cpu_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Bench requests
   input  wire logic [1:0] cmd_i,
   input  wire logic       deep_i,
   input  wire logic       core_clk_en_i,
   // Processor outputs
   output logic            wfe_o,
   output logic            wfi_o,
   output logic            deep_sleep_bit_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wfe_o            <= 1'b0;
         wfi_o            <= 1'b0;
         deep_sleep_bit_o <= 1'b0;
      end else begin
         wfe_o            <= (cmd_i == 2'h1) && core_clk_en_i;
         wfi_o            <= (cmd_i == 2'h2) && core_clk_en_i;
         deep_sleep_bit_o <= deep_i;
      end
   end
endmodule // lpwc_cpu_model

`default_nettype wire

// ---- lpwc_pkg.sv ----
// Purpose: Shared constants for the low-power mode and wake-up controller.
// Assumes: One clock domain at 25 MHz; register port with one-cycle read latency.
// Notes:   All offsets are byte addresses of aligned 32-bit words.
// What this block does
// - Active core clock from RC, crystal or PLL.
// - Wait-for-event with deep sleep enters backup.
// - Backup turns regulator and core supply off.
// - Enabled pin, input or alarm leaves backup.
// - Backup wake restores supply, core restarts reset.
// - After backup wake, I/O become pulled-up inputs.
// - Wait-for-event, low-power select, no deep sleep: wait.
// - Wait stops core, peripheral, memory clocks; powered.
// - Wait restart completes under ten microseconds.
// - Wait exits on inputs, alarms or USB.
// - Sleep stops only core clock.
// - Sleep wakes on interrupt, or event after wait-for-event.
// - Low level on sixteen inputs, or RTC, RTT or USB, requests fast start.
// - Fast start request is asynchronous, clockless.
// - Fast start restarts RC, selects it, clocks core.
// - After wait or backup wake run from RC; PLL stays off.

// ************************************************************
// Package
// ************************************************************
package lpwc_pkg;
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_PERIPH_EN = 8'h04;
   localparam logic [7:0] OFS_WAKE_EN   = 8'h08;
   localparam logic [7:0] OFS_FS_EN     = 8'h0c;
   localparam logic [7:0] OFS_DEBOUNCE  = 8'h10;
   localparam logic [7:0] OFS_MODE      = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h1c;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h20;
   // CTRL field positions.
   localparam int CTRL_LPS     = 0;
   localparam int CTRL_SRC_LO  = 1;
   localparam int CTRL_PLL     = 3;
   localparam int CTRL_DIV_LO  = 4;
   localparam int CTRL_PIO_REL = 7;
   // Wake enable positions above the sixteen input bits.
   localparam int WE_FORCE_WAKEUP_PIN = 16;
   localparam int WE_ALM  = 17;
   localparam int IRQ_BACKUP = 0;
   localparam int IRQ_WAIT   = 1;
   localparam int IRQ_SLEEP  = 2;
   localparam logic [1:0] SRC_FRC  = 2'h0;
   localparam logic [1:0] SRC_XTAL = 2'h1;
   localparam logic [1:0] SRC_PLL  = 2'h2;
   localparam logic [7:0] RST_PERIPH_EN = 8'hff;
   localparam logic [7:0] RST_DEBOUNCE  = 8'h04;
   // Timing.
   localparam int CLK_PERIOD_NS   = 40;
   localparam int REG_START_NS    = 400000;
   localparam int REG_START_CYC   = REG_START_NS / CLK_PERIOD_NS;
   localparam int FRC_START_NS    = 2000;
   localparam int FRC_START_CYC   = (FRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_EXIT_NS    = 10000;
   localparam int WAIT_EXIT_CYC   = WAIT_EXIT_NS / CLK_PERIOD_NS;
   localparam int CORE_RST_CYC    = 4;
   typedef enum logic [6:0] {
      ST_ACTIVE    = 7'h01,
      ST_SLEEP     = 7'h02,
      ST_WAIT      = 7'h04,
      ST_FRC_START = 7'h08,
      ST_BACKUP    = 7'h10,
      ST_REG_START = 7'h20,
      ST_CORE_RST  = 7'h40
   } lpwc_state_type;
endpackage

// ---- lpwc_top.sv ----
// Purpose: Low-power mode entry, clock and supply gating, and wake-up sequencing.
// Assumes: core_clk_i is the always-running backup-domain clock.
// Notes:   fast_startup_o is a purely combinational path for the clock controller.
`timescale 1ns/1ps
`default_nettype none

module lpwc_top #(
   parameter int REG_CYC = lpwc_pkg::REG_START_CYC
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        sys_rst_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // Processor
   input  wire logic        cpu_wfe_i,
   input  wire logic        cpu_wfi_i,
   input  wire logic        deep_sleep_bit_i,
   input  wire logic        cpu_irq_i,
   input  wire logic        cpu_event_i,
   // Wake sources
   input  wire logic        force_wakeup_pin_n_i,
   input  wire logic [15:0] wakeup_inputs_i,
   input  wire logic        supply_monitor_alarm_i,
   input  wire logic        rtc_alarm_i,
   input  wire logic        real_time_tick_timer_alarm_i,
   input  wire logic        usb_wakeup_i,
   // Clock and power control
   output logic             core_clk_en_o,
   output logic      [7:0]  periph_clk_en_o,
   output logic             mem_clk_en_o,
   output logic      [1:0]  clk_src_sel_o,
   output logic      [2:0]  clk_div_o,
   output logic             main_pll_en_o,
   output logic             fast_rc_enable_o,
   output logic             fast_startup_o,
   output logic             regulator_on_ctrl_o,
   output logic             core_reset_o,
   output logic             pio_safe_o,
   output logic             irq_o
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      lpwc_pkg::lpwc_state_type st;
      logic [20:0] s1_wake;
      logic [20:0] s2_wake;
      logic        s1_fs;
      logic        s2_fs;
      logic [15:0] wk_ref;
      logic [7:0]  deb_cnt;
      logic [13:0] tmr;
      logic        entry_wfe;
      logic        lps;
      logic [1:0]  clk_src;
      logic        pll_en;
      logic [2:0]  clk_div;
      logic [7:0]  periph_en;
      logic [20:0] wake_en;
      logic [18:0] fs_en;
      logic [7:0]  deb_cfg;
      logic [2:0]  irq_st;
      logic [2:0]  irq_en;
      logic        pio_safe;
      logic [31:0] rdata;
   } lpwc_regs_type;

   lpwc_regs_type state_reg;
   lpwc_regs_type state_next;

   logic        in_wait;
   logic [18:0] fs_src;
   logic        force_wakeup_pin_low;
   logic        wk_trans;
   logic        deb_cand;
   logic        deb_ok;
   logic        alarm_wake;
   logic        sleep_wake;
   logic [2:0]  irq_set;

   assign in_wait = (state_reg.st == lpwc_pkg::ST_WAIT);
   // Low level on an input, an RTC or RTT alarm, or the USB wake forms the fast-start set of nineteen.
   assign fs_src = {usb_wakeup_i, real_time_tick_timer_alarm_i, rtc_alarm_i, ~wakeup_inputs_i};
   // No clock is involved here, so the clock controller sees the request at once.
   assign fast_startup_o = in_wait & (|(fs_src & state_reg.fs_en));

   // Backup wake qualification on synchronised copies only.
   assign force_wakeup_pin_low   = state_reg.wake_en[lpwc_pkg::WE_FORCE_WAKEUP_PIN] & ~state_reg.s2_wake[16];
   assign wk_trans   = |((state_reg.s2_wake[15:0] ^ state_reg.wk_ref) & state_reg.wake_en[15:0]);
   assign deb_cand   = force_wakeup_pin_low | wk_trans;
   assign deb_ok     = deb_cand & (state_reg.deb_cnt >= state_reg.deb_cfg);
   assign alarm_wake = |(state_reg.s2_wake[19:17] & state_reg.wake_en[19:17]);
   // A wait-for-interrupt sleep ignores events.
   assign sleep_wake = cpu_irq_i | (state_reg.entry_wfe & (cpu_event_i | state_reg.s2_fs));

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      irq_set    = 3'h0;
      // The first stage feeds only the second.
      state_next.s1_wake = {usb_wakeup_i, real_time_tick_timer_alarm_i, rtc_alarm_i,
                            supply_monitor_alarm_i, force_wakeup_pin_n_i, wakeup_inputs_i};
      state_next.s2_wake = state_reg.s1_wake;
      state_next.s1_fs   = fast_startup_o;
      state_next.s2_fs   = state_reg.s1_fs;
      state_next.rdata   = 32'h0;
      state_next.deb_cnt = 8'h0;
      if (deb_cand && state_reg.deb_cnt != 8'hff) begin
         state_next.deb_cnt = state_reg.deb_cnt + 8'h1;
      end

      case (state_reg.st)
         lpwc_pkg::ST_ACTIVE: begin
            if (cpu_wfe_i && deep_sleep_bit_i) begin
               state_next.st       = lpwc_pkg::ST_BACKUP;
               state_next.wk_ref   = state_reg.s2_wake[15:0];
               state_next.pio_safe = 1'b1;
            end else if (cpu_wfe_i && state_reg.lps && !deep_sleep_bit_i) begin
               state_next.st = lpwc_pkg::ST_WAIT;
            end else if (cpu_wfi_i || cpu_wfe_i) begin
               state_next.st        = lpwc_pkg::ST_SLEEP;
               state_next.entry_wfe = cpu_wfe_i;
            end
         end
         lpwc_pkg::ST_SLEEP: begin
            if (sleep_wake) begin
               state_next.st         = lpwc_pkg::ST_ACTIVE;
               irq_set[lpwc_pkg::IRQ_SLEEP] = 1'b1;
            end
         end
         lpwc_pkg::ST_WAIT: begin
            if (state_reg.s2_fs) begin
               state_next.st = lpwc_pkg::ST_FRC_START;
               state_next.tmr = 14'h0;
            end
         end
         lpwc_pkg::ST_FRC_START: begin
            state_next.tmr = state_reg.tmr + 14'h1;
            if (state_reg.tmr == 14'(lpwc_pkg::FRC_START_CYC - 1)) begin
               state_next.st      = lpwc_pkg::ST_ACTIVE;
               state_next.clk_src = lpwc_pkg::SRC_FRC;
               state_next.pll_en  = 1'b0;
               irq_set[lpwc_pkg::IRQ_WAIT] = 1'b1;
            end
         end
         lpwc_pkg::ST_BACKUP: begin
            if (deb_ok || alarm_wake) begin
               state_next.st  = lpwc_pkg::ST_REG_START;
               state_next.tmr = 14'h0;
            end
         end
         lpwc_pkg::ST_REG_START: begin
            state_next.tmr = state_reg.tmr + 14'h1;
            if (state_reg.tmr == 14'(REG_CYC - 1)) begin
               state_next.st  = lpwc_pkg::ST_CORE_RST;
               state_next.tmr = 14'h0;
            end
         end
         lpwc_pkg::ST_CORE_RST: begin
            state_next.tmr     = state_reg.tmr + 14'h1;
            state_next.clk_src = lpwc_pkg::SRC_FRC;
            state_next.pll_en  = 1'b0;
            if (state_reg.tmr == 14'(lpwc_pkg::CORE_RST_CYC - 1)) begin
               state_next.st = lpwc_pkg::ST_ACTIVE;
               irq_set[lpwc_pkg::IRQ_BACKUP] = 1'b1;
            end
         end
         default: begin
            state_next.st = lpwc_pkg::ST_ACTIVE;
         end
      endcase

      // ************************************************************
      // Register port
      // ************************************************************
      if (reg_wr_i) begin
         case (reg_addr_i)
            lpwc_pkg::OFS_CTRL: begin
               state_next.lps     = reg_wdata_i[lpwc_pkg::CTRL_LPS];
               state_next.pll_en  = reg_wdata_i[lpwc_pkg::CTRL_PLL];
               state_next.clk_div = reg_wdata_i[lpwc_pkg::CTRL_DIV_LO +: 3];
               // Reserved source code falls back to the RC oscillator.
               state_next.clk_src = (reg_wdata_i[lpwc_pkg::CTRL_SRC_LO +: 2] == 2'h3) ?
                                    lpwc_pkg::SRC_FRC : reg_wdata_i[lpwc_pkg::CTRL_SRC_LO +: 2];
               if (reg_wdata_i[lpwc_pkg::CTRL_PIO_REL]) begin
                  state_next.pio_safe = 1'b0;
               end
            end
            lpwc_pkg::OFS_PERIPH_EN: state_next.periph_en = reg_wdata_i[7:0];
            lpwc_pkg::OFS_WAKE_EN:   state_next.wake_en = reg_wdata_i[20:0];
            lpwc_pkg::OFS_FS_EN:     state_next.fs_en = reg_wdata_i[18:0];
            lpwc_pkg::OFS_DEBOUNCE:  state_next.deb_cfg = reg_wdata_i[7:0];
            lpwc_pkg::OFS_IRQ_EN:    state_next.irq_en = reg_wdata_i[2:0];
            default: begin
            end
         endcase
      end
      // A new event wins over a clear in the same cycle.
      state_next.irq_st = state_reg.irq_st | irq_set;
      if (reg_wr_i && reg_addr_i == lpwc_pkg::OFS_IRQ_CLR) begin
         state_next.irq_st = (state_reg.irq_st & ~reg_wdata_i[2:0]) | irq_set;
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            lpwc_pkg::OFS_CTRL:      state_next.rdata = {24'h0, state_reg.pio_safe, state_reg.clk_div,
                                                         state_reg.pll_en, state_reg.clk_src, state_reg.lps};
            lpwc_pkg::OFS_PERIPH_EN: state_next.rdata = {24'h0, state_reg.periph_en};
            lpwc_pkg::OFS_WAKE_EN:   state_next.rdata = {11'h0, state_reg.wake_en};
            lpwc_pkg::OFS_FS_EN:     state_next.rdata = {13'h0, state_reg.fs_en};
            lpwc_pkg::OFS_DEBOUNCE:  state_next.rdata = {24'h0, state_reg.deb_cfg};
            // Software polls the RC enable bit here before trusting wait entry.
            lpwc_pkg::OFS_MODE:      state_next.rdata = {23'h0, fast_rc_enable_o, 1'b0, state_reg.st};
            lpwc_pkg::OFS_IRQ_STAT:  state_next.rdata = {29'h0, state_reg.irq_st};
            lpwc_pkg::OFS_IRQ_EN:    state_next.rdata = {29'h0, state_reg.irq_en};
            default:                 state_next.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_reg           <= '0;
         state_reg.st        <= lpwc_pkg::ST_ACTIVE;
         state_reg.periph_en <= lpwc_pkg::RST_PERIPH_EN;
         state_reg.deb_cfg   <= lpwc_pkg::RST_DEBOUNCE;
         state_reg.clk_src   <= lpwc_pkg::SRC_FRC;
      end else begin
         state_reg <= state_next;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   logic run_or_sleep;
   assign run_or_sleep = (state_reg.st == lpwc_pkg::ST_ACTIVE) || (state_reg.st == lpwc_pkg::ST_SLEEP);
   assign core_clk_en_o   = (state_reg.st == lpwc_pkg::ST_ACTIVE) ||
                            (state_reg.st == lpwc_pkg::ST_CORE_RST);
   assign periph_clk_en_o = run_or_sleep ? state_reg.periph_en : 8'h0;
   assign mem_clk_en_o    = run_or_sleep;
   assign clk_src_sel_o   = state_reg.clk_src;
   assign clk_div_o       = state_reg.clk_div;
   assign main_pll_en_o   = state_reg.pll_en;
   // The RC is stopped in wait and backup and restarted by the exit sequences.
   assign fast_rc_enable_o = !(in_wait || state_reg.st == lpwc_pkg::ST_BACKUP);
   // Supply stays up in wait and sleep so that state is kept.
   assign regulator_on_ctrl_o = (state_reg.st != lpwc_pkg::ST_BACKUP);
   assign core_reset_o = (state_reg.st == lpwc_pkg::ST_BACKUP) || (state_reg.st == lpwc_pkg::ST_REG_START) ||
                         (state_reg.st == lpwc_pkg::ST_CORE_RST);
   assign pio_safe_o  = state_reg.pio_safe;
   assign irq_o       = |(state_reg.irq_st & state_reg.irq_en);
   assign reg_rdata_o = state_reg.rdata;

   // ************************************************************
   // Checks
   // ************************************************************
   localparam int WAIT_BOUND = 60;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_backup_entry: assert property ((state_reg.st == lpwc_pkg::ST_ACTIVE) && cpu_wfe_i && deep_sleep_bit_i
      |=> state_reg.st == lpwc_pkg::ST_BACKUP) else $error("backup not entered");
   chk_backup_supply: assert property ((state_reg.st == lpwc_pkg::ST_BACKUP)
      |-> !regulator_on_ctrl_o && core_reset_o && !core_clk_en_o) else $error("supply on in backup");
   chk_backup_alarm: assert property ((state_reg.st == lpwc_pkg::ST_BACKUP) && state_reg.s2_wake[18]
      && state_reg.wake_en[18] |=> state_reg.st == lpwc_pkg::ST_REG_START) else $error("alarm ignored");
   chk_core_restart: assert property ($rose(state_reg.st == lpwc_pkg::ST_REG_START)
      |-> core_reset_o [*8] ##1 regulator_on_ctrl_o) else $error("core left reset early");
   chk_pio_safe: assert property ((state_reg.st == lpwc_pkg::ST_CORE_RST) |-> pio_safe_o)
      else $error("pio not safe after backup");
   chk_wait_entry: assert property ((state_reg.st == lpwc_pkg::ST_ACTIVE) && cpu_wfe_i && state_reg.lps
      && !deep_sleep_bit_i |=> in_wait) else $error("wait not entered");
   chk_wait_clocks: assert property (in_wait |-> !core_clk_en_o && !mem_clk_en_o && periph_clk_en_o == 8'h0
      && regulator_on_ctrl_o) else $error("clock running in wait");
   chk_wait_exit_time: assert property (in_wait && fast_startup_o |-> ##[1:WAIT_BOUND] core_clk_en_o)
      else $error("wait exit too slow");
   chk_sleep_clocks: assert property ((state_reg.st == lpwc_pkg::ST_SLEEP) |-> !core_clk_en_o && mem_clk_en_o)
      else $error("wrong clocks in sleep");
   chk_sleep_wfi_hold: assert property ((state_reg.st == lpwc_pkg::ST_SLEEP) && !state_reg.entry_wfe
      && !cpu_irq_i |=> state_reg.st == lpwc_pkg::ST_SLEEP) else $error("sleep left without irq");
   chk_fast_start_gate: assert property (fast_startup_o |-> in_wait) else $error("fast start outside wait");
   chk_wake_on_rc: assert property ($past(state_reg.st) == lpwc_pkg::ST_FRC_START && state_reg.st ==
      lpwc_pkg::ST_ACTIVE |-> clk_src_sel_o == lpwc_pkg::SRC_FRC && !main_pll_en_o) else $error("not on rc");
   chk_sync_delay: assert property (in_wait && $rose(fast_startup_o) |=> in_wait)
      else $error("unsynchronised wake");

   cov_backup_cycle: cover property ($rose(state_reg.st == lpwc_pkg::ST_CORE_RST));
   cov_wait_cycle: cover property (in_wait ##1 state_reg.st == lpwc_pkg::ST_FRC_START);
   cov_sleep_event: cover property ((state_reg.st == lpwc_pkg::ST_SLEEP) && state_reg.entry_wfe && cpu_event_i);

endmodule // lpwc_top

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the low-power mode and wake-up controller.
// Assumes: REG_CYC is shortened to 20 so that a backup wake stays quick.
// Notes:   Expected status bits come from an integer model kept beside the run.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam int REG_CYC = 20;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic [31:0] rd_val;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        irq_in = 1'b0;
   logic        evt = 1'b0;
   logic [15:0] wk = 16'hffff;
   logic        rtc = 1'b0;
   logic [1:0]  cmd = 2'h0;
   logic        deep = 1'b0;
   logic        wfe, wfi, deep_s, cclk, mclk, pll, frc, fs, reg_on, crst, pio, irq;
   logic [7:0]  pclk;
   logic [1:0]  src;
   logic [2:0]  div;
   logic        force_wakeup_pin_n = 1'b1;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          mdl_stat = 0;
   int          mdl_per = 255;
   int          i;
   integer      seed = 32'ha711;

   always #20 clk = ~clk;

   lpwc_top #(.REG_CYC(REG_CYC)) lpwc_top_inst (
      .core_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .cpu_wfe_i(wfe), .cpu_wfi_i(wfi), .deep_sleep_bit_i(deep_s),
      .cpu_irq_i(irq_in), .cpu_event_i(evt), .force_wakeup_pin_n_i(force_wakeup_pin_n), .wakeup_inputs_i(wk),
      .supply_monitor_alarm_i(1'b0), .rtc_alarm_i(rtc), .real_time_tick_timer_alarm_i(1'b0),
      .usb_wakeup_i(1'b0), .core_clk_en_o(cclk), .periph_clk_en_o(pclk), .mem_clk_en_o(mclk),
      .clk_src_sel_o(src), .clk_div_o(div), .main_pll_en_o(pll), .fast_rc_enable_o(frc), .fast_startup_o(fs),
      .regulator_on_ctrl_o(reg_on), .core_reset_o(crst), .pio_safe_o(pio), .irq_o(irq));

   lpwc_cpu_model lpwc_cpu_model_inst (
      .clk_i(clk), .rst_i(rst), .cmd_i(cmd), .deep_i(deep), .core_clk_en_i(cclk),
      .wfe_o(wfe), .wfi_o(wfi), .deep_sleep_bit_o(deep_s));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic run_instr(input logic [1:0] c, input logic d);
      @(posedge clk);
      cmd <= c;
      deep <= d;
      @(posedge clk);
      cmd <= 2'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic chk_mode(input logic [6:0] st, input logic rc);
      rreg(lpwc_pkg::OFS_MODE, rd_val);
      chk(rd_val, {23'h0, rc, 1'b0, st});
   endtask

   task automatic chk_stat;
      rreg(lpwc_pkg::OFS_IRQ_STAT, rd_val);
      chk(rd_val, mdl_stat);
   endtask

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // The whole run needs well under two thousand cycles; the ceiling leaves wide margin.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count = err_count + 1;
         wrap_up();
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      chk_mode(lpwc_pkg::ST_ACTIVE, 1'b1);
      rreg(8'h24, rd_val);
      chk(rd_val, 32'h0);
      chk({reg_on, crst, cclk, src, pll}, 6'b101000);
      mdl_per = $random(seed) & 32'hff;
      wreg(lpwc_pkg::OFS_PERIPH_EN, mdl_per);
      wreg(lpwc_pkg::OFS_IRQ_EN, 32'h7);
      $display("test reset done");
      // A wait-for-interrupt sleep must ignore a bare event.
      run_instr(2'h2, 1'b0);
      chk({cclk, mclk, pclk}, {2'b01, mdl_per[7:0]});
      chk_mode(lpwc_pkg::ST_SLEEP, 1'b1);
      @(posedge clk);
      evt <= 1'b1;
      @(posedge clk);
      evt <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk(cclk, 1'b0);
      @(posedge clk);
      irq_in <= 1'b1;
      @(posedge clk);
      irq_in <= 1'b0;
      #1 chk(cclk, 1'b1);
      mdl_stat = mdl_stat | 4;
      chk_stat();
      chk(irq, 1'b1);
      $display("test sleep done");
      // The PLL is left on before wait entry to show that the wake switches it off.
      wreg(lpwc_pkg::OFS_FS_EN, 32'h8);
      wreg(lpwc_pkg::OFS_CTRL, 32'h9);
      run_instr(2'h1, 1'b0);
      chk({cclk, mclk, pclk, reg_on, frc}, {2'b00, 8'h00, 2'b10});
      chk_mode(lpwc_pkg::ST_WAIT, 1'b0);
      @(posedge clk);
      wk[3] <= 1'b0;
      #1 chk(fs, 1'b1);
      for (i = 0; i < 400 && cclk !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk(i < lpwc_pkg::WAIT_EXIT_CYC, 1'b1);
      chk({src, pll, frc}, 4'b0001);
      @(posedge clk);
      wk[3] <= 1'b1;
      mdl_stat = mdl_stat | 2;
      chk_stat();
      $display("test wait done");
      wreg(lpwc_pkg::OFS_CTRL, 32'h0);
      wreg(lpwc_pkg::OFS_WAKE_EN, 32'h40000);
      run_instr(2'h1, 1'b1);
      chk({reg_on, crst, pio, cclk}, 4'b0110);
      chk_mode(lpwc_pkg::ST_BACKUP, 1'b0);
      @(posedge clk);
      rtc <= 1'b1;
      for (i = 0; i < 200 && crst !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      rtc <= 1'b0;
      #1 chk({reg_on, cclk, pio, crst}, 4'b1110);
      chk(i >= REG_CYC, 1'b1);
      chk_mode(lpwc_pkg::ST_ACTIVE, 1'b1);
      mdl_stat = mdl_stat | 1;
      chk_stat();
      wreg(lpwc_pkg::OFS_CTRL, 32'hd0);
      #1 chk({pio, div}, 4'b0101);
      // The force-wakeup pin must pass the debounce count before the supply comes back.
      wreg(lpwc_pkg::OFS_WAKE_EN, 32'h10000);
      run_instr(2'h1, 1'b1);
      @(posedge clk);
      force_wakeup_pin_n <= 1'b0;
      for (i = 0; i < 200 && crst !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      chk(i > lpwc_pkg::RST_DEBOUNCE + REG_CYC, 1'b1);
      @(posedge clk);
      force_wakeup_pin_n <= 1'b1;
      chk_mode(lpwc_pkg::ST_ACTIVE, 1'b1);
      $display("test backup done");
      wreg(lpwc_pkg::OFS_IRQ_EN, 32'h0);
      #1 chk(irq, 1'b0);
      wreg(lpwc_pkg::OFS_IRQ_CLR, 32'h7);
      mdl_stat = 0;
      chk_stat();
      rreg(lpwc_pkg::OFS_IRQ_CLR, rd_val);
      chk(rd_val, 32'h0);
      $display("test interrupt done");
      wrap_up();
   end
endmodule // testbench

`default_nettype wire
